/* File: clock_gen_smbus_config_regs_bench.sv */
// Self-checking bench for the clock generator configuration registers.
module clock_gen_smbus_config_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] DEV  = 8'h5c;       // Arbitrary device code.
    localparam logic [3:0] REV  = 4'h3;        // Arbitrary revision code.
    localparam logic [3:0] MKR  = 4'h9;        // Arbitrary maker code.
    localparam logic [7:0] ID_B = {REV, MKR};
    logic        clk, resetn, sclk, sda_host, sdata_line, sdata_o, sdata_oe;
    logic        aux_clock_b_enable, aux_clock_a_enable, pll_prog_enable;
    logic        aux_clock_b_two_loads, aux_clock_a_two_loads;
    logic        pll_ratio_valid;
    logic [2:0]  swing_select;
    logic [7:0]  readback_count, aux_view;
    logic [9:0]  feedback_divider;
    logic [5:0]  reference_divider;
    logic [10:0] pll_mult;
    logic [6:0]  pll_div;
    int          num_errors, num_checks;

    // Wired-AND data line with pull-up; an enabled device pulls it low.
    assign sdata_line = sda_host & ~(sdata_oe & ~sdata_o);
    assign aux_view = {aux_clock_b_enable, aux_clock_a_enable,
                       aux_clock_b_two_loads, aux_clock_a_two_loads,
                       1'b0, swing_select};

    smbcfg_regs #(.DEVICE_CODE(DEV), .REVISION_CODE(REV),
                  .MAKER_CODE(MKR)) uut (.sdata_i(sdata_line), .*);

    smbcfg_host_model host (.clk(clk), .sdata_line(sdata_line), .sclk(sclk),
                            .sda_o(sda_host));

    // Free-running 50 MHz clock.
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
        end
    endtask

    // Reads back bytes from an offset and compares count and contents.
    task automatic expect_bytes(input logic [7:0] ofs, input logic [7:0] c,
                                input logic [7:0] exp[$]);
        logic [7:0] cnt;
        logic [7:0] q[$];
        host.read_regs(ofs, exp.size(), cnt, q);
        check(16'(cnt), 16'(c));
        foreach (exp[i]) check(16'(q[i]), 16'(exp[i]));
    endtask

    task automatic test_reset_state();
        logic [7:0] e[$];
        e = {8'hf5, DEV, ID_B, 8'h09, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        check(16'(aux_view), 16'h00f5);
        check(16'(readback_count), 16'h0009);
        check(16'({pll_prog_enable, pll_ratio_valid}), 16'h0000);
        expect_bytes(8'h05, 8'h09, e);
        $display("test_reset_state done");
    endtask

    // Back-to-back write over the identity bytes, which must not change.
    task automatic test_aux_identity();
        host.write_regs(8'h05, {8'h0a, 8'hff, 8'h00});
        check(16'(aux_view), 16'h0002);
        host.write_regs(8'h05, {8'h5b});
        check(16'(aux_view), 16'h0053);
        expect_bytes(8'h05, 8'h09, {8'h5b, DEV, ID_B});
        $display("test_aux_identity done");
    endtask

    // Divider fields, gate on and off, reserved bytes written over.
    task automatic test_divider();
        logic [7:0] e[$];
        e = {8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h85, 8'h3c};
        host.write_regs(8'h0a, {8'h80, 8'h11, 8'h22, 8'h33, 8'h44});
        host.write_regs(8'h0f, {8'h85, 8'h3c});
        check(16'(feedback_divider), 16'h013c);
        check(16'(reference_divider), 16'h0005);
        check(16'(pll_mult), 16'h0144);
        check(16'(pll_div), 16'h0007);
        check(16'({pll_prog_enable, pll_ratio_valid}), 16'h0003);
        expect_bytes(8'h0a, 8'h09, e);
        host.write_regs(8'h0a, {8'h00});
        host.write_regs(8'h0f, {8'h01});
        check(16'(feedback_divider), 16'h003c);
        check(16'(pll_mult), 16'h0144);
        check(16'(pll_div), 16'h0007);
        check(16'(pll_ratio_valid), 16'h0000);
        host.write_regs(8'h0a, {8'h80});
        check(16'(pll_mult), 16'h0044);
        check(16'(pll_div), 16'h0003);
        $display("test_divider done");
    endtask

    // Shortened readback past the end: unmapped byte, then idle fill.
    task automatic test_count();
        host.write_regs(8'h08, {8'h02});
        check(16'(readback_count), 16'h0002);
        expect_bytes(8'h10, 8'h02, {8'h3c, 8'h00, 8'hff});
        check(16'(host.ack_errs), 16'h0000);
        $display("test_count done");
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Main sequence after a 12-cycle reset.
    initial begin
        num_errors = 0;
        num_checks = 0;
        resetn = 1'b0;
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        test_reset_state();
        test_aux_identity();
        test_divider();
        test_count();
        conclude();
    end

    // Nine times the expected run length means a hang.
    initial begin
        repeat (60000) @(posedge clk);
        num_errors++;
        conclude();
    end
endmodule

/* File: smbcfg_evt_if.sv */
// Serial bus line events passed from the pin front end to the register block.
interface smbcfg_evt_if;
    logic start;
    logic stop;
    logic rise;
    logic fall;
    logic sda;

    modport src (output start, stop, rise, fall, sda);
    modport dst (input start, stop, rise, fall, sda);
endinterface

/* File: smbcfg_host_model.sv */
// Behavioural serial bus host that reaches the configuration registers.
module smbcfg_host_model (
    input  wire logic clk,
    input  wire logic sdata_line,
    output logic      sclk,
    output logic      sda_o
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PHASE = 4; // Clocks per bus clock phase, above three.
    int ack_errs;

    // Bus idles high; an open-drain host only ever pulls low.
    initial begin
        sclk = 1'b1;
        sda_o = 1'b1;
        ack_errs = 0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Data changes only while the bus clock is low; sampled mid high.
    task automatic bit_io(input logic b, output logic q);
        sda_o <= b;
        tick(PHASE);
        sclk <= 1'b1;
        tick(PHASE / 2);
        q = sdata_line;
        tick(PHASE / 2);
        sclk <= 1'b0;
        tick(1);
    endtask

    // Serves as start and as repeated start.
    task automatic start();
        sda_o <= 1'b1;
        tick(PHASE);
        sclk <= 1'b1;
        tick(PHASE);
        sda_o <= 1'b0;
        tick(PHASE);
        sclk <= 1'b0;
        tick(1);
    endtask

    task automatic stop();
        sda_o <= 1'b0;
        tick(PHASE);
        sclk <= 1'b1;
        tick(PHASE);
        sda_o <= 1'b1;
        tick(PHASE);
    endtask

    // A missing acknowledge is counted for the bench to judge.
    task automatic send_byte(input logic [7:0] v);
        logic a;
        for (int i = 7; i >= 0; i--) bit_io(v[i], a);
        bit_io(1'b1, a);
        if (a !== 1'b0) ack_errs++;
    endtask

    task automatic get_byte(input logic last, output logic [7:0] v);
        logic b;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
        bit_io(last, b);
    endtask

    // Block write; the count byte is sent but the device ignores it.
    task automatic write_regs(input logic [7:0] ofs, input logic [7:0] d[$]);
        start();
        send_byte({smbcfg_pkg::SLAVE_ADDR, 1'b0});
        send_byte(ofs);
        send_byte(8'(d.size()));
        foreach (d[i]) send_byte(d[i]);
        stop();
    endtask

    // Block read of n bytes; the last one is refused to end the read.
    task automatic read_regs(input logic [7:0] ofs, input int n,
                             output logic [7:0] cnt, output logic [7:0] q[$]);
        logic [7:0] v;
        q = {};
        start();
        send_byte({smbcfg_pkg::SLAVE_ADDR, 1'b0});
        send_byte(ofs);
        start();
        send_byte({smbcfg_pkg::SLAVE_ADDR, 1'b1});
        get_byte(1'b0, cnt);
        for (int i = 0; i < n; i++) begin
            get_byte(i == n - 1, v);
            q.push_back(v);
        end
        stop();
    endtask
endmodule

/* File: smbcfg_pin_events.sv */
// Detects start, stop and clock edges on the serial bus pins.
module smbcfg_pin_events (
    input  wire logic   clk,
    input  wire logic   resetn,
    input  wire logic   sclk,
    input  wire logic   sdata_i,
    smbcfg_evt_if.src   evt
);

    logic scl_q;
    logic sda_q;

    // Previous line levels; idle bus lines rest high.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= sclk;
            sda_q <= sdata_i;
        end
    end

    // Data falling or rising while the clock stays high frames a transfer.
    assign evt.start = scl_q & sclk & sda_q & ~sdata_i;
    assign evt.stop  = scl_q & sclk & ~sda_q & sdata_i;
    assign evt.rise  = ~scl_q & sclk;
    assign evt.fall  = scl_q & ~sclk;
    assign evt.sda   = sdata_i;

endmodule

/* File: smbcfg_pkg.sv */
// Constants and types shared by the clock generator configuration registers.
package smbcfg_pkg;

    // ************************************************************
    // Register byte offsets
    // ************************************************************
    localparam logic [7:0] OFS_AUX       = 8'h05;
    localparam logic [7:0] OFS_PART_ID   = 8'h06;
    localparam logic [7:0] OFS_MAKER_REV = 8'h07;
    localparam logic [7:0] OFS_RB_LEN    = 8'h08;
    localparam logic [7:0] OFS_SPARE9    = 8'h09;
    localparam logic [7:0] OFS_PLL_GATE  = 8'h0a;
    localparam logic [7:0] OFS_RSVD_LO   = 8'h0b;
    localparam logic [7:0] OFS_RSVD_HI   = 8'h0e;
    localparam logic [7:0] OFS_DIV_HI    = 8'h0f;
    localparam logic [7:0] OFS_FB_LO     = 8'h10;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int AUX_B_EN_BIT  = 7;
    localparam int AUX_A_EN_BIT  = 6;
    localparam int AUX_B_DRV_BIT = 5;
    localparam int AUX_A_DRV_BIT = 4;
    localparam int SWING_MSB     = 2;
    localparam int SWING_LSB     = 0;
    localparam int GATE_BIT      = 7;
    localparam int FB_BIT8_POS   = 7;
    localparam int FB_BIT9_POS   = 6;
    localparam int REF_MSB       = 5;

    // ************************************************************
    // Reset values and read fill bytes
    // ************************************************************
    localparam logic [7:0] RST_AUX    = 8'hf5;
    localparam logic [7:0] RST_RB_LEN = 8'h09;
    localparam logic [7:0] RST_SPARE  = 8'h00;
    localparam logic [7:0] RST_GATE   = 8'h00;
    localparam logic [7:0] RST_DIV_HI = 8'h00;
    localparam logic [7:0] RST_FB_LO  = 8'h00;
    localparam logic [7:0] READ_NONE  = 8'h00;
    localparam logic [7:0] READ_IDLE  = 8'hff;

    // ************************************************************
    // Serial bus framing and divider offsets
    // ************************************************************
    localparam logic [6:0] SLAVE_ADDR    = 7'h69;
    localparam logic [3:0] LAST_DATA_BIT = 4'h7;
    localparam logic [3:0] ACK_SLOT      = 4'h8;
    localparam int         FB_OFFSET     = 8;
    localparam int         REF_OFFSET    = 2;

    // One-hot states of the serial byte engine.
    typedef enum logic [5:0] {
        SMBCFG_IDLE  = 6'h01,
        SMBCFG_ADDR  = 6'h02,
        SMBCFG_CMD   = 6'h04,
        SMBCFG_COUNT = 6'h08,
        SMBCFG_WDATA = 6'h10,
        SMBCFG_RDATA = 6'h20
    } smbcfg_state_t;

endpackage

/* File: smbcfg_pll_ratio.sv */
// Registers the CPU PLL multiply and divide terms from the divider fields.
module smbcfg_pll_ratio #(
    parameter int FB_W  = 10,
    parameter int REF_W = 6
) (
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic             enable,
    input  wire logic [FB_W-1:0]  fb_div,
    input  wire logic [REF_W-1:0] ref_div,
    output logic      [FB_W:0]    mult,
    output logic      [REF_W:0]   div,
    output logic                  valid
);

    if (FB_W < 4 || REF_W < 2) begin : g_width_check
        $error("smbcfg_pll_ratio: divider widths too small");
    end

    // ************************************************************
    // Ratio terms
    // ************************************************************

    // Terms only follow the fields while programming is allowed.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mult  <= '0;
            div   <= '0;
            valid <= 1'b0;
        end else begin
            valid <= enable;
            if (enable) begin
                mult <= {1'b0, fb_div}
                        + (FB_W+1)'(smbcfg_pkg::FB_OFFSET);
                div  <= {1'b0, ref_div}
                        + (REF_W+1)'(smbcfg_pkg::REF_OFFSET);
            end
        end
    end

endmodule

/* File: smbcfg_regs.sv */
// Configuration and identity registers of the clock generator, bus-accessed.
module smbcfg_regs #(
    parameter logic [7:0] DEVICE_CODE   = 8'ha3, // Arbitrary value.
    parameter logic [3:0] REVISION_CODE = 4'h2,  // Arbitrary value.
    parameter logic [3:0] MAKER_CODE    = 4'h6,  // Arbitrary value.
    parameter logic [6:0] BUS_ADDR      = smbcfg_pkg::SLAVE_ADDR
) (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        sclk,
    input  wire logic        sdata_i,
    output logic             sdata_o,
    output logic             sdata_oe,
    output logic             aux_clock_b_enable,
    output logic             aux_clock_a_enable,
    output logic             aux_clock_b_two_loads,
    output logic             aux_clock_a_two_loads,
    output logic [2:0]       swing_select,
    output logic [7:0]       readback_count,
    output logic             pll_prog_enable,
    output logic [9:0]       feedback_divider,
    output logic [5:0]       reference_divider,
    output logic [10:0]      pll_mult,
    output logic [6:0]       pll_div,
    output logic             pll_ratio_valid
);

    if (BUS_ADDR == 7'h00) begin : g_addr_check
        $error("smbcfg_regs: bus address zero is the general call");
    end

    // ************************************************************
    // Declarations
    // ************************************************************
    smbcfg_evt_if evt ();

    smbcfg_pkg::smbcfg_state_t state_q;
    logic [3:0] bit_cnt_q;
    logic [7:0] shift_q;
    logic [7:0] ptr_q;
    logic [7:0] tx_q;
    logic [7:0] rd_left_q;
    logic       rw_q;
    logic       host_nack_q;
    logic       sda_oe_q;

    logic [7:0] aux_q;
    logic [7:0] rb_len_q;
    logic [7:0] spare_q;
    logic [7:0] gate_q;
    logic [7:0] div_hi_q;
    logic [7:0] fb_lo_q;

    logic       byte_done;
    logic       slot_done;
    logic       addr_hit;
    logic       rx_state;
    logic       wr_en;
    logic       go_read;
    logic [7:0] reg_rd;
    logic [7:0] load_byte;

    // ************************************************************
    // Pin front end
    // ************************************************************
    smbcfg_pin_events u_pins (
        .clk     (clk),
        .resetn  (resetn),
        .sclk    (sclk),
        .sdata_i (sdata_i),
        .evt     (evt.src)
    );

    // ************************************************************
    // Byte framing
    // ************************************************************

    // Eighth data bit done, and acknowledge slot done, on clock fall.
    assign byte_done = evt.fall && (bit_cnt_q == smbcfg_pkg::LAST_DATA_BIT);
    assign slot_done = evt.fall && (bit_cnt_q == smbcfg_pkg::ACK_SLOT);
    assign addr_hit  = (shift_q[7:1] == BUS_ADDR);
    assign rx_state  = (state_q == smbcfg_pkg::SMBCFG_ADDR)
                    || (state_q == smbcfg_pkg::SMBCFG_CMD)
                    || (state_q == smbcfg_pkg::SMBCFG_COUNT)
                    || (state_q == smbcfg_pkg::SMBCFG_WDATA);
    assign wr_en     = byte_done && (state_q == smbcfg_pkg::SMBCFG_WDATA);

    // A read continues after the address or after a host acknowledge.
    assign go_read = slot_done
                  && (((state_q == smbcfg_pkg::SMBCFG_ADDR) && rw_q)
                  || ((state_q == smbcfg_pkg::SMBCFG_RDATA) && !host_nack_q));

    // Counts bit and ack falls; a start parks it so its own fall is skipped.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bit_cnt_q <= 4'h0;
        end else if (evt.start || evt.stop) begin
            bit_cnt_q <= evt.start ? 4'hf : 4'h0;
        end else if (evt.fall) begin
            if (bit_cnt_q == smbcfg_pkg::ACK_SLOT) begin
                bit_cnt_q <= 4'h0;
            end else begin
                bit_cnt_q <= bit_cnt_q + 4'h1;
            end
        end
    end

    // Samples data bits on rising clock, most significant first.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            shift_q <= 8'h00;
        end else if (evt.rise && (bit_cnt_q < smbcfg_pkg::ACK_SLOT)) begin
            shift_q <= {shift_q[6:0], evt.sda};
        end
    end

    // Captures the host answer in the acknowledge slot of a read byte.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            host_nack_q <= 1'b0;
        end else if (evt.rise && (bit_cnt_q == smbcfg_pkg::ACK_SLOT)) begin
            host_nack_q <= evt.sda;
        end
    end

    // ************************************************************
    // Transfer sequencing
    // ************************************************************

    // Walks address, command, count, then write data bytes; a read address goes straight to read data bytes.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= smbcfg_pkg::SMBCFG_IDLE;
            rw_q    <= 1'b0;
        end else if (evt.start) begin
            state_q <= smbcfg_pkg::SMBCFG_ADDR;
        end else if (evt.stop) begin
            state_q <= smbcfg_pkg::SMBCFG_IDLE;
        end else if (byte_done && (state_q == smbcfg_pkg::SMBCFG_ADDR)) begin
            rw_q <= shift_q[0];
            if (!addr_hit) begin
                state_q <= smbcfg_pkg::SMBCFG_IDLE;
            end
        end else if (slot_done) begin
            unique case (state_q)
                smbcfg_pkg::SMBCFG_ADDR: begin
                    state_q <= rw_q ? smbcfg_pkg::SMBCFG_RDATA
                                    : smbcfg_pkg::SMBCFG_CMD;
                end
                smbcfg_pkg::SMBCFG_CMD:   state_q <= smbcfg_pkg::SMBCFG_COUNT;
                smbcfg_pkg::SMBCFG_COUNT: state_q <= smbcfg_pkg::SMBCFG_WDATA;
                smbcfg_pkg::SMBCFG_WDATA: state_q <= smbcfg_pkg::SMBCFG_WDATA;
                smbcfg_pkg::SMBCFG_RDATA: begin
                    if (host_nack_q) begin
                        state_q <= smbcfg_pkg::SMBCFG_IDLE;
                    end
                end
                smbcfg_pkg::SMBCFG_IDLE:  state_q <= smbcfg_pkg::SMBCFG_IDLE;
            endcase
        end
    end

    // Register pointer: set by the command byte, stepped per data byte.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ptr_q <= 8'h00;
        end else if (byte_done && (state_q == smbcfg_pkg::SMBCFG_CMD)) begin
            ptr_q <= shift_q;
        end else if (wr_en) begin
            ptr_q <= ptr_q + 8'h01;
        end else if (go_read && (state_q == smbcfg_pkg::SMBCFG_RDATA)
                     && (rd_left_q != 8'h00)) begin
            ptr_q <= ptr_q + 8'h01;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rd_left_q <= 8'h00;
        end else if (go_read && (state_q == smbcfg_pkg::SMBCFG_ADDR)) begin
            rd_left_q <= rb_len_q;
        end else if (go_read && (rd_left_q != 8'h00)) begin
            rd_left_q <= rd_left_q - 8'h01;
        end
    end

    // ************************************************************
    // Read path
    // ************************************************************

    // Selects the register byte at the pointer.
    always_comb begin
        unique case (ptr_q)
            smbcfg_pkg::OFS_AUX:       reg_rd = aux_q;
            smbcfg_pkg::OFS_PART_ID:   reg_rd = DEVICE_CODE;
            smbcfg_pkg::OFS_MAKER_REV: reg_rd = {REVISION_CODE, MAKER_CODE};
            smbcfg_pkg::OFS_RB_LEN:    reg_rd = rb_len_q;
            smbcfg_pkg::OFS_SPARE9:    reg_rd = spare_q;
            smbcfg_pkg::OFS_PLL_GATE:  reg_rd = gate_q;
            smbcfg_pkg::OFS_DIV_HI:    reg_rd = div_hi_q;
            smbcfg_pkg::OFS_FB_LO:     reg_rd = fb_lo_q;
            default:                   reg_rd = smbcfg_pkg::READ_NONE;
        endcase
    end

    // First read byte is the count, then registers until it runs out.
    always_comb begin
        if (state_q == smbcfg_pkg::SMBCFG_ADDR) begin
            load_byte = rb_len_q;
        end else if (rd_left_q == 8'h00) begin
            load_byte = smbcfg_pkg::READ_IDLE;
        end else begin
            load_byte = reg_rd;
        end
    end

    // Holds the byte being sent, moved left on the falls after its first seven bits.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tx_q <= 8'h00;
        end else if (go_read) begin
            tx_q <= load_byte;
        end else if (evt.fall && (state_q == smbcfg_pkg::SMBCFG_RDATA)
                     && (bit_cnt_q < smbcfg_pkg::LAST_DATA_BIT)) begin
            tx_q <= {tx_q[6:0], 1'b0};
        end
    end

    // Data line is changed only while the clock is low, save the release at a start or stop.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sda_oe_q <= 1'b0;
        end else if (evt.start || evt.stop) begin
            sda_oe_q <= 1'b0;
        end else if (byte_done) begin
            sda_oe_q <= rx_state
                        && !((state_q == smbcfg_pkg::SMBCFG_ADDR) && !addr_hit);
        end else if (slot_done) begin
            sda_oe_q <= go_read && !load_byte[7];
        end else if (evt.fall && (state_q == smbcfg_pkg::SMBCFG_RDATA)) begin
            sda_oe_q <= !tx_q[6];
        end
    end

    assign sdata_o  = 1'b0;
    assign sdata_oe = sda_oe_q;

    // ************************************************************
    // Register file
    // ************************************************************

    // Stores data bytes; unlisted offsets take the byte and drop it.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            aux_q    <= smbcfg_pkg::RST_AUX;
            rb_len_q <= smbcfg_pkg::RST_RB_LEN;
            spare_q  <= smbcfg_pkg::RST_SPARE;
            gate_q   <= smbcfg_pkg::RST_GATE;
            div_hi_q <= smbcfg_pkg::RST_DIV_HI;
            fb_lo_q  <= smbcfg_pkg::RST_FB_LO;
        end else if (wr_en) begin
            unique case (ptr_q)
                smbcfg_pkg::OFS_AUX:      aux_q    <= shift_q;
                smbcfg_pkg::OFS_RB_LEN:   rb_len_q <= shift_q;
                smbcfg_pkg::OFS_SPARE9:   spare_q  <= shift_q;
                smbcfg_pkg::OFS_PLL_GATE: gate_q   <= shift_q;
                smbcfg_pkg::OFS_DIV_HI:   div_hi_q <= shift_q;
                smbcfg_pkg::OFS_FB_LO:    fb_lo_q  <= shift_q;
                default:                  ;
            endcase
        end
    end

    // ************************************************************
    // Control outputs
    // ************************************************************

    assign aux_clock_b_enable = aux_q[smbcfg_pkg::AUX_B_EN_BIT];
    assign aux_clock_a_enable = aux_q[smbcfg_pkg::AUX_A_EN_BIT];
    assign aux_clock_b_two_loads = aux_q[smbcfg_pkg::AUX_B_DRV_BIT];
    assign aux_clock_a_two_loads = aux_q[smbcfg_pkg::AUX_A_DRV_BIT];
    assign swing_select = aux_q[smbcfg_pkg::SWING_MSB:smbcfg_pkg::SWING_LSB];
    assign readback_count = rb_len_q;
    assign pll_prog_enable = gate_q[smbcfg_pkg::GATE_BIT];
    assign feedback_divider = {div_hi_q[smbcfg_pkg::FB_BIT9_POS],
                               div_hi_q[smbcfg_pkg::FB_BIT8_POS], fb_lo_q};
    assign reference_divider = div_hi_q[smbcfg_pkg::REF_MSB:0];

    smbcfg_pll_ratio #(
        .FB_W  (10),
        .REF_W (6)
    ) u_ratio (
        .clk     (clk),
        .resetn  (resetn),
        .enable  (pll_prog_enable),
        .fb_div  (feedback_divider),
        .ref_div (reference_divider),
        .mult    (pll_mult),
        .div     (pll_div),
        .valid   (pll_ratio_valid)
    );

endmodule

/* File: smbcfg_regs_sva.sv */
// Concurrent checks on the configuration register outputs.
module smbcfg_regs_sva (
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic        sclk,
    input wire logic        sdata_oe,
    input wire logic        aux_clock_b_enable,
    input wire logic        aux_clock_a_enable,
    input wire logic        aux_clock_b_two_loads,
    input wire logic        aux_clock_a_two_loads,
    input wire logic [2:0]  swing_select,
    input wire logic [7:0]  readback_count,
    input wire logic        pll_prog_enable,
    input wire logic [9:0]  feedback_divider,
    input wire logic [5:0]  reference_divider,
    input wire logic [10:0] pll_mult,
    input wire logic [6:0]  pll_div,
    input wire logic        pll_ratio_valid
);
    // All checks share the register clock and its reset.
    default clocking dcb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    // ********************************************************
    // Register updates follow bus writes
    // ********************************************************
    // enable moves on write
    property p_aux_b_en;
        $changed(aux_clock_b_enable) |-> !sclk;
    endproperty
    a_aux_b_en: assert property (p_aux_b_en)
        else $error("aux b enable glitch");
    property p_aux_a_en;
        $changed(aux_clock_a_enable) |=> !sclk;
    endproperty
    a_aux_a_en: assert property (p_aux_a_en)
        else $error("aux a enable glitch");
    property p_two_loads;
        sclk && $past(sclk) |->
            $stable({aux_clock_b_two_loads, aux_clock_a_two_loads});
    endproperty
    a_two_loads: assert property (p_two_loads)
        else $error("drive strength glitch");
    property p_swing;
        $changed(swing_select) |-> !sclk ##1 !sclk;
    endproperty
    a_swing: assert property (p_swing)
        else $error("swing select glitch");
    property p_count;
        $changed(readback_count) |=> !sclk;
    endproperty
    a_count: assert property (p_count)
        else $error("readback count glitch");
    property p_valid;
        1'b1 |=> pll_ratio_valid == $past(pll_prog_enable);
    endproperty
    a_valid: assert property (p_valid)
        else $error("ratio valid lag wrong");
    property p_feedback;
        $changed(feedback_divider) |-> !sclk;
    endproperty
    a_feedback: assert property (p_feedback)
        else $error("feedback divider glitch");
    property p_reference;
        sclk [*2] |-> $stable(reference_divider);
    endproperty
    a_reference: assert property (p_reference)
        else $error("reference divider glitch");

    // ********************************************************
    // Frequency ratio terms
    // ********************************************************
    // multiply term
    property p_mult;
        (pll_prog_enable && $stable(feedback_divider)) [*3] |->
            pll_mult == 11'(feedback_divider) + 11'd8;
    endproperty
    a_mult: assert property (p_mult)
        else $error("multiply term wrong");
    property p_div;
        (pll_prog_enable && $stable(reference_divider)) [*3] |->
            pll_div == 7'(reference_divider) + 7'd2;
    endproperty
    a_div: assert property (p_div)
        else $error("divide term wrong");
    property p_hold;
        !pll_prog_enable [*2] |=> $stable(pll_mult) && $stable(pll_div);
    endproperty
    a_hold: assert property (p_hold)
        else $error("ratio terms moved while gated");

    // Main scenarios reached.
    c_valid: cover property ($rose(pll_ratio_valid));
    c_aux_off: cover property ($fell(aux_clock_b_enable));
    c_ack: cover property ($rose(sdata_oe));
endmodule

bind smbcfg_regs smbcfg_regs_sva u_sva (.*);
